/* verilog/trfs_pkg.sv */
// Shared constants, frame header layout and helpers for the token frame scheduler.
// Assumes both link ends run on one 20 MHz clock.
package trfs_pkg;
  localparam int          NODE_W         = 8;
  localparam int          LEN_W          = 16;
  localparam int          CNT_W          = 11;
  localparam int          HDR_LEN_MIN    = 64;
  localparam int          HDR_LEN_MAX    = 96;
  localparam int          HDR_LEN_DEF    = 64;
  localparam int          SEG_MAX        = 1024;
  localparam logic [1:0]  MISS_LIMIT     = 2'h3;
  localparam logic [15:0] PORT_CYC       = 16'hD6D8;
  localparam logic [15:0] PORT_MSG       = 16'hD6D9;
  localparam logic [15:0] PORT_JOIN      = 16'hD6DA;
  // Header byte positions
  localparam int          HO_KIND        = 0;
  localparam int          HO_TOK         = 1;
  localparam int          HO_DST         = 2;
  localparam int          HO_SRC         = 3;
  localparam int          HO_PORT_H      = 4;
  localparam int          HO_PORT_L      = 5;
  localparam int          HO_LEN_H       = 6;
  localparam int          HO_LEN_L       = 7;
  localparam int          CLK_NS         = 50;
  localparam int          TOKEN_WATCH_US = 10000;
  localparam int          WATCH_CYC      = TOKEN_WATCH_US * 1000 / CLK_NS;

  typedef enum logic [1:0] {
    K_TOKEN = 2'h0,
    K_CYC   = 2'h1,
    K_MSG   = 2'h2,
    K_JOIN  = 2'h3
  } trfs_kind_e;

  function automatic logic [15:0] trfs_port(input trfs_kind_e kind);
    unique case (kind)
      K_MSG:   trfs_port = PORT_MSG;
      K_JOIN:  trfs_port = PORT_JOIN;
      default: trfs_port = PORT_CYC;
    endcase
  endfunction : trfs_port

  // Unused header bytes are zero
  function automatic logic [7:0] trfs_hdr_byte(input logic [CNT_W-1:0] idx,
                                               input trfs_kind_e       kind,
                                               input logic             tok,
                                               input logic [7:0]       dst,
                                               input logic [7:0]       src,
                                               input logic [LEN_W-1:0] len);
    logic [15:0] port;
    port = trfs_port(kind);
    unique case (int'(idx))
      HO_KIND:   trfs_hdr_byte = {6'h00, kind};
      HO_TOK:    trfs_hdr_byte = {7'h00, tok};
      HO_DST:    trfs_hdr_byte = dst;
      HO_SRC:    trfs_hdr_byte = src;
      HO_PORT_H: trfs_hdr_byte = port[15:8];
      HO_PORT_L: trfs_hdr_byte = port[7:0];
      HO_LEN_H:  trfs_hdr_byte = len[15:8];
      HO_LEN_L:  trfs_hdr_byte = len[7:0];
      default:   trfs_hdr_byte = 8'h00;
    endcase
  endfunction : trfs_hdr_byte
endpackage : trfs_pkg

/* verilog/trfs_link_if.sv */
// Frame byte streams between this node and the peer network.
// One byte per valid cycle; last marks the final byte of a frame; no back-pressure.
`timescale 1ns/1ns
`default_nettype none
interface trfs_link_if;
  logic       d2n_valid;
  logic       d2n_last;
  logic [7:0] d2n_data;
  logic       n2d_valid;
  logic       n2d_last;
  logic [7:0] n2d_data;

  modport dev  (output d2n_valid, d2n_last, d2n_data, input  n2d_valid, n2d_last, n2d_data);
  modport peer (input  d2n_valid, d2n_last, d2n_data, output n2d_valid, n2d_last, n2d_data);
endinterface : trfs_link_if
`default_nettype wire

/* verilog/trfs_node.sv */
// Token scheduler and framer of the local node: joins, holds and passes the token,
// lays out message, cyclic and token frames behind a protocol header.
// Assumes payload memory answers pl_data_i for pl_addr_o in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module trfs_node import trfs_pkg::*; #(
  parameter int HDR_LEN   = HDR_LEN_DEF,
  parameter int WATCH_LEN = WATCH_CYC
) (
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  trfs_link_if.dev               lnk,
  input  wire logic [NODE_W-1:0] my_node_i,
  input  wire logic              join_i,
  input  wire logic [LEN_W-1:0]  cyc_len_i,
  input  wire logic [LEN_W-1:0]  msg_len_i,
  input  wire logic [7:0]        pl_data_i,
  output logic      [LEN_W-1:0]  pl_addr_o,
  output logic                   pl_msg_o,
  output logic                   joined_o,
  output logic                   holding_o,
  output logic                   depart_o
);
  typedef enum logic [2:0] {
    S_OFF  = 3'h0,
    S_IDLE = 3'h1,
    S_HOLD = 3'h2,
    S_SEND = 3'h3,
    S_JOIN = 3'h4
  } trfs_st_e;

  localparam logic [CNT_W-1:0] HDR_CNT = CNT_W'(HDR_LEN);
  localparam logic [LEN_W-1:0] SEG_LEN = LEN_W'(SEG_MAX);
  localparam int               NNODE   = 1 << NODE_W;

  trfs_st_e          st_r;
  trfs_kind_e        f_kind_r;
  logic              f_tok_r;
  logic [7:0]        f_dst_r;
  logic [LEN_W-1:0]  f_len_r;
  logic [LEN_W-1:0]  f_off_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [LEN_W-1:0]  cyc_rem_r;
  logic [LEN_W-1:0]  cyc_off_r;
  logic              msg_pend_r;
  logic              tok_done_r;
  logic              drop_r;
  logic [CNT_W-1:0]  frm_end;
  logic [6:0]        rx_idx_r;
  logic              rx_tok_r;
  logic [7:0]        rx_dst_r;
  logic [7:0]        rx_src_r;
  logic              rx_end;
  logic              tok_to_me;
  logic              tok_rival;
  logic              gain;
  logic [31:0]       wd_r;
  logic              wd_exp;
  logic [NNODE-1:0]  tbl_r;
  logic [NNODE-1:0]  seen_r;
  logic [1:0]        miss_r [NNODE];

  // Next participant above me, wrapping to the lowest
  function automatic logic [7:0] next_node(input logic [NNODE-1:0] tbl,
                                           input logic [7:0]       me);
    logic [7:0] n;
    logic       hit;
    next_node = me;
    hit = 1'b0;
    for (int k = 1; k < NNODE; k++) begin
      n = 8'(int'(me) + k);
      if (!hit && tbl[n]) begin
        next_node = n;
        hit = 1'b1;
      end
    end
  endfunction : next_node

  assign rx_end    = lnk.n2d_valid && lnk.n2d_last && rx_idx_r > 7'(HO_LEN_L);
  assign tok_to_me = rx_end && rx_tok_r && rx_dst_r == my_node_i;
  assign tok_rival = rx_end && rx_tok_r && rx_src_r < my_node_i;
  assign wd_exp    = st_r == S_IDLE && wd_r >= 32'(WATCH_LEN);
  assign gain      = st_r == S_IDLE && (tok_to_me || wd_exp);
  assign frm_end   = HDR_CNT + CNT_W'(f_len_r) - 11'h001;

  // Receive header parse
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_idx_r  <= 7'h00;
      rx_tok_r  <= 1'b0;
      rx_dst_r  <= 8'h00;
      rx_src_r  <= 8'h00;
    end else if (lnk.n2d_valid) begin
      rx_idx_r <= lnk.n2d_last ? 7'h00 : (rx_idx_r == 7'h7F ? rx_idx_r : rx_idx_r + 7'h01);
      unique case (int'(rx_idx_r))
        HO_TOK:  rx_tok_r  <= lnk.n2d_data[0];
        HO_DST:  rx_dst_r  <= lnk.n2d_data;
        HO_SRC:  rx_src_r  <= lnk.n2d_data;
        default: ;
      endcase
    end
  end

  // Token watch: restarted by any token on the wire or by our own hold
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      wd_r <= 32'h0000_0000;
    else if ((rx_end && rx_tok_r) || st_r != S_IDLE)
      wd_r <= 32'h0000_0000;
    else if (!wd_exp)
      wd_r <= wd_r + 32'h0000_0001;
  end

  // Participation table and departure watch; a missing holder counts as a miss
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tbl_r    <= '0;
      seen_r   <= '0;
      depart_o <= 1'b0;
      for (int i = 0; i < NNODE; i++)
        miss_r[i] <= 2'h0;
    end else begin
      depart_o <= 1'b0;
      if (st_r == S_JOIN)
        tbl_r[my_node_i] <= 1'b1;
      if (rx_end) begin
        tbl_r[rx_src_r] <= 1'b1;
        if (rx_tok_r)
          seen_r[rx_src_r] <= 1'b1;
      end
      if (gain) begin
        seen_r <= '0;
        for (int i = 0; i < NNODE; i++) begin
          if (tbl_r[i] && 8'(i) != my_node_i) begin
            // A token arriving with the gain still belongs to the ending rotation
            if (seen_r[i] || (rx_end && rx_tok_r && rx_src_r == 8'(i))) begin
              miss_r[i] <= 2'h0;
            end else if (miss_r[i] == MISS_LIMIT - 2'h1) begin
              miss_r[i] <= 2'h0;
              tbl_r[i]  <= 1'b0;
              depart_o  <= 1'b1;
            end else begin
              miss_r[i] <= miss_r[i] + 2'h1;
            end
          end
        end
      end
    end
  end

  // Frame scheduling
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r       <= S_OFF;
      f_kind_r   <= K_TOKEN;
      f_tok_r    <= 1'b0;
      f_dst_r    <= 8'h00;
      f_len_r    <= '0;
      f_off_r    <= '0;
      cnt_r      <= '0;
      cyc_rem_r  <= '0;
      cyc_off_r  <= '0;
      msg_pend_r <= 1'b0;
      tok_done_r <= 1'b0;
      drop_r     <= 1'b0;
    end else begin
      if (st_r != S_IDLE && st_r != S_OFF && tok_rival)
        drop_r <= 1'b1;
      unique case (st_r)
        S_OFF: begin
          if (join_i) begin
            st_r     <= S_JOIN;
            f_kind_r <= K_JOIN;
            f_tok_r  <= 1'b0;
            f_len_r  <= '0;
            cnt_r    <= '0;
          end
        end
        S_JOIN: begin
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == frm_end)
            st_r <= S_IDLE;
        end
        S_IDLE: begin
          if (gain) begin
            st_r       <= S_HOLD;
            msg_pend_r <= msg_len_i != '0;
            cyc_rem_r  <= cyc_len_i;
            cyc_off_r  <= '0;
            tok_done_r <= 1'b0;
            drop_r     <= 1'b0;
          end
        end
        S_HOLD: begin
          cnt_r   <= '0;
          f_dst_r <= next_node(tbl_r, my_node_i);
          if (drop_r || tok_done_r) begin
            st_r <= S_IDLE;
          end else if (msg_pend_r) begin
            st_r       <= S_SEND;
            msg_pend_r <= 1'b0;
            f_kind_r   <= K_MSG;
            f_tok_r    <= 1'b0;
            f_len_r    <= msg_len_i;
            f_off_r    <= '0;
          end else if (cyc_rem_r != '0) begin
            st_r      <= S_SEND;
            f_kind_r  <= K_CYC;
            f_tok_r   <= cyc_rem_r <= SEG_LEN;
            f_len_r   <= cyc_rem_r > SEG_LEN ? SEG_LEN : cyc_rem_r;
            f_off_r   <= cyc_off_r;
            cyc_rem_r <= cyc_rem_r > SEG_LEN ? cyc_rem_r - SEG_LEN : '0;
            cyc_off_r <= cyc_off_r + SEG_LEN;
          end else begin
            st_r     <= S_SEND;
            f_kind_r <= K_TOKEN;
            f_tok_r  <= 1'b1;
            f_len_r  <= '0;
          end
        end
        S_SEND: begin
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == frm_end) begin
            st_r       <= S_HOLD;
            tok_done_r <= f_tok_r;
          end
        end
        default: st_r <= S_OFF;
      endcase
    end
  end

  // Byte pipeline: payload address runs one byte ahead, so memory data lands with its byte
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pl_addr_o     <= '0;
      pl_msg_o      <= 1'b0;
      lnk.d2n_valid <= 1'b0;
      lnk.d2n_last  <= 1'b0;
      lnk.d2n_data  <= 8'h00;
    end else begin
      lnk.d2n_valid <= 1'b0;
      lnk.d2n_last  <= 1'b0;
      if (st_r == S_SEND || st_r == S_JOIN) begin
        pl_addr_o     <= f_off_r + LEN_W'(cnt_r + 11'h001 - HDR_CNT);
        pl_msg_o      <= f_kind_r == K_MSG;
        lnk.d2n_valid <= 1'b1;
        lnk.d2n_last  <= cnt_r == frm_end;
        lnk.d2n_data  <= (cnt_r < HDR_CNT) ?
                         trfs_hdr_byte(cnt_r, f_kind_r, f_tok_r, f_dst_r,
                                       my_node_i, f_len_r) : pl_data_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      joined_o  <= 1'b0;
      holding_o <= 1'b0;
    end else begin
      joined_o  <= st_r != S_OFF && st_r != S_JOIN;
      holding_o <= st_r == S_HOLD || st_r == S_SEND;
    end
  end
endmodule : trfs_node
`default_nettype wire

/* verilog/trfs_peer.sv */
// Peer end of the token link: takes a token addressed to it and passes it on
// in a header-only token frame; may issue a fresh token on request.
// Assumes the same clock as the local node.
`timescale 1ns/1ns
`default_nettype none
module trfs_peer import trfs_pkg::*; #(
  parameter int HDR_LEN = HDR_LEN_DEF
) (
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  trfs_link_if.peer              lnk,
  input  wire logic [NODE_W-1:0] my_node_i,
  input  wire logic [NODE_W-1:0] next_node_i,
  input  wire logic              issue_i,
  output logic                   holding_o,
  output logic                   token_seen_o
);
  localparam logic [CNT_W-1:0] HDR_CNT = CNT_W'(HDR_LEN);

  logic [6:0]       rx_idx_r;
  logic             rx_tok_r;
  logic [7:0]       rx_dst_r;
  logic             rx_end;
  logic [CNT_W-1:0] cnt_r;

  assign rx_end = lnk.d2n_valid && lnk.d2n_last && rx_idx_r > 7'(HO_LEN_L);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_idx_r     <= 7'h00;
      rx_tok_r     <= 1'b0;
      rx_dst_r     <= 8'h00;
      token_seen_o <= 1'b0;
    end else begin
      token_seen_o <= rx_end && rx_tok_r;
      if (lnk.d2n_valid) begin
        rx_idx_r <= lnk.d2n_last ? 7'h00 : (rx_idx_r == 7'h7F ? rx_idx_r : rx_idx_r + 7'h01);
        if (int'(rx_idx_r) == HO_TOK)
          rx_tok_r <= lnk.d2n_data[0];
        if (int'(rx_idx_r) == HO_DST)
          rx_dst_r <= lnk.d2n_data;
      end
    end
  end

  // Transmits only while holding; an issue request stands in for a lost token
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      holding_o     <= 1'b0;
      cnt_r         <= '0;
      lnk.n2d_valid <= 1'b0;
      lnk.n2d_last  <= 1'b0;
      lnk.n2d_data  <= 8'h00;
    end else begin
      lnk.n2d_valid <= 1'b0;
      lnk.n2d_last  <= 1'b0;
      if (!holding_o) begin
        cnt_r <= '0;
        if ((rx_end && rx_tok_r && rx_dst_r == my_node_i) || issue_i)
          holding_o <= 1'b1;
      end else begin
        lnk.n2d_valid <= 1'b1;
        lnk.n2d_last  <= cnt_r == HDR_CNT - 11'h001;
        lnk.n2d_data  <= trfs_hdr_byte(cnt_r, K_TOKEN, 1'b1, next_node_i, my_node_i, '0);
        cnt_r         <= cnt_r + 11'h001;
        if (cnt_r == HDR_CNT - 11'h001)
          holding_o <= 1'b0;
      end
    end
  end
endmodule : trfs_peer
`default_nettype wire

/* verification/trfs_monitor.sv */
// Checker on the node-peer frame link.
// Assumes one clock domain; sits beside the link interface in the bench.
`timescale 1ns/1ns
`default_nettype none
module trfs_monitor import trfs_pkg::*; #(
  parameter int HDR_LEN = HDR_LEN_DEF
) (
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic       d2n_valid,
  input wire logic       d2n_last,
  input wire logic [7:0] d2n_data,
  input wire logic       n2d_valid,
  input wire logic       n2d_last,
  input wire logic [7:0] n2d_data
);
  logic [15:0] cnt_r;
  logic [15:0] ncnt_r;
  logic [15:0] len_r;
  logic [1:0]  kind_r;
  logic [7:0]  port_lo;

  assign port_lo = (kind_r == K_MSG) ? PORT_MSG[7:0] :
                   (kind_r == K_JOIN) ? PORT_JOIN[7:0] : PORT_CYC[7:0];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_r <= 16'h0000;
    else if (d2n_valid) cnt_r <= d2n_last ? 16'h0000 : cnt_r + 16'h0001;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) ncnt_r <= 16'h0000;
    else if (n2d_valid) ncnt_r <= n2d_last ? 16'h0000 : ncnt_r + 16'h0001;
  end

  // Length latched so the frame end can be judged against it
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      kind_r <= 2'h0;
      len_r  <= 16'h0000;
    end else if (d2n_valid) begin
      if (cnt_r == 16'h0000) kind_r <= d2n_data[1:0];
      if (cnt_r == 16'h0006) len_r[15:8] <= d2n_data;
      if (cnt_r == 16'h0007) len_r[7:0] <= d2n_data;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_start;
    d2n_valid && cnt_r == 16'h0000;
  endsequence
  sequence s_hdr_run;
    (d2n_valid && !d2n_last) [*8];
  endsequence
  sequence s_port_pair;
    d2n_data == PORT_CYC[15:8] ##1 d2n_data == port_lo;
  endsequence

  header_run_a: assert property (s_start |-> s_hdr_run)
    else $error("header bytes broken up");
  kind_byte_a: assert property (s_start |-> d2n_data[7:2] == 6'h00)
    else $error("bad kind byte");
  msg_no_token_a: assert property (d2n_valid && cnt_r == 16'h0001 && d2n_data[0]
    |-> kind_r == K_TOKEN || kind_r == K_CYC) else $error("token on wrong frame kind");
  fixed_port_a: assert property (d2n_valid && cnt_r == 16'h0004
    |-> s_port_pair) else $error("bad port");
  seg_limit_a: assert property (d2n_valid && cnt_r == 16'h0007
    |-> {len_r[15:8], d2n_data} <= 16'h0400) else $error("segment too long");
  bare_frame_a: assert property (d2n_valid && cnt_r == 16'h0007 && kind_r[0] == kind_r[1]
    |-> {len_r[15:8], d2n_data} == 16'h0000) else $error("payload on bare frame");
  pad_zero_a: assert property (d2n_valid && cnt_r >= 16'h0008 && int'(cnt_r) < HDR_LEN
    |-> d2n_data == 8'h00) else $error("header padding not zero");
  frame_size_a: assert property (d2n_valid && d2n_last
    |-> int'(cnt_r) == HDR_LEN - 1 + int'(len_r)) else $error("frame size wrong");
  frame_cont_a: assert property (d2n_valid && !d2n_last |=> d2n_valid)
    else $error("gap inside frame");
  peer_token_a: assert property (n2d_valid && ncnt_r == 16'h0001
    |-> n2d_data == 8'h01 && $past(n2d_data) == 8'h00) else $error("peer frame not a token");
endmodule : trfs_monitor
`default_nettype wire

/* verification/token_ring_frame_scheduler_tb.sv */
// Bench: local node and peer end joined by the link interface.
// Assumes a shortened token watch; node frames are captured off the link.
`timescale 1ns/1ns
`default_nettype none
module token_ring_frame_scheduler_tb import trfs_pkg::*;;
  localparam int HDR   = 80;
  localparam int WATCH = 200;
  localparam int LIMIT = 30000;

  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        join_i     = 1'b0;
  logic        issue_i    = 1'b0;
  logic [7:0]  peer_node  = 8'h07;
  logic [15:0] cyc_len    = 16'h0000;
  logic [15:0] msg_len    = 16'h0000;
  logic [15:0] pl_addr;
  logic        pl_msg;
  logic        joined;
  logic        holding;
  logic        depart;
  logic        peer_hold;
  logic        peer_seen;
  int          peer_seen_cnt = 0;
  logic [95:0] frames[$];
  logic [95:0] cur          = 96'h0;
  int          idx          = 0;
  int          tok_cnt      = 0;
  int          depart_cnt   = 0;
  int          err_count    = 0;
  int          total_checks = 0;
  int          cyc_cnt      = 0;

  trfs_link_if lnk ();
  trfs_node #(.HDR_LEN(HDR), .WATCH_LEN(WATCH)) u_trfs_node (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .lnk(lnk), .my_node_i(8'h02),
    .join_i(join_i), .cyc_len_i(cyc_len), .msg_len_i(msg_len),
    .pl_data_i({pl_msg, pl_addr[10:4]}), .pl_addr_o(pl_addr), .pl_msg_o(pl_msg),
    .joined_o(joined), .holding_o(holding), .depart_o(depart));
  trfs_peer #(.HDR_LEN(HDR)) u_trfs_peer (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .lnk(lnk), .my_node_i(peer_node),
    .next_node_i(8'h02), .issue_i(issue_i), .holding_o(peer_hold), .token_seen_o(peer_seen));
  trfs_monitor #(.HDR_LEN(HDR)) u_trfs_monitor (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .d2n_valid(lnk.d2n_valid),
    .d2n_last(lnk.d2n_last), .d2n_data(lnk.d2n_data), .n2d_valid(lnk.n2d_valid),
    .n2d_last(lnk.n2d_last), .n2d_data(lnk.n2d_data));

  always #25 core_clk_i = ~core_clk_i;

  // Capture: header bytes 0..7, padding OR, first payload byte, size
  always @(posedge core_clk_i) begin
    cyc_cnt++;
    if (depart === 1'b1) depart_cnt++;
    if (peer_seen === 1'b1) peer_seen_cnt++;
    if (lnk.d2n_valid === 1'b1) begin
      if (idx < 8) cur[8*idx +: 8] = lnk.d2n_data;
      else if (idx < HDR) cur[71:64] = cur[71:64] | lnk.d2n_data;
      else if (idx == HDR) cur[79:72] = lnk.d2n_data;
      idx++;
      if (lnk.d2n_last === 1'b1) begin
        cur[95:80] = 16'(idx);
        frames.push_back(cur);
        if (cur[8] === 1'b1) tok_cnt++;
        cur = 96'h0;
        idx = 0;
      end
    end
    if (cyc_cnt == LIMIT) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #5;
  endtask : tick

  task automatic wait_tok();
    int n;
    int k;
    n = tok_cnt;
    k = 0;
    while (tok_cnt == n && k < 5000) begin
      tick(1);
      k++;
    end
    check("token frame", 32'(tok_cnt != n), 32'h1);
  endtask : wait_tok

  task automatic exp_frame(input int i, input logic [1:0] kd, input logic tk,
                           input logic [15:0] ln, input logic [7:0] p0);
    logic [95:0] f;
    f = (i < frames.size()) ? frames[i] : 96'h0;
    check("kind", f[1:0], kd);
    check("token flag", f[8], tk);
    check("port", {f[39:32], f[47:40]}, (kd == K_MSG) ? PORT_MSG : PORT_CYC);
    check("length", {f[55:48], f[63:56]}, ln);
    check("size", f[95:80], 16'(HDR) + ln);
    check("padding", f[71:64], 8'h00);
    check("first payload", f[79:72], p0);
    if (tk) begin
      check("destination", f[23:16], peer_node);
      check("sender", f[31:24], 8'h02);
    end
  endtask : exp_frame

  // One full rotation of the node with the given pending lengths
  task automatic rotate(input logic [15:0] msg, input logic [15:0] cyc);
    logic [15:0] rest;
    logic [15:0] ln;
    logic [15:0] off;
    int          k;
    wait_tok();
    msg_len = msg;
    cyc_len = cyc;
    frames.delete();
    wait_tok();
    k = 0;
    rest = cyc;
    if (msg != 16'h0000) begin
      exp_frame(k, K_MSG, 1'b0, msg, 8'h80);
      k++;
    end
    do begin
      ln = (rest > 16'h0400) ? 16'h0400 : rest;
      off = cyc - rest;
      exp_frame(k, (cyc == 16'h0000) ? K_TOKEN : K_CYC, rest == ln, ln,
                (ln == 16'h0000) ? 8'h00 : {1'b0, off[10:4]});
      rest = rest - ln;
      k++;
    end while (rest != 16'h0000);
    check("frame count", frames.size(), k);
  endtask : rotate

  task automatic t_reset();
    tick(WATCH + 20);
    check("silent before join", frames.size(), 0);
    check("joined", joined, 1'b0);
    check("holding", holding, 1'b0);
  endtask : t_reset

  task automatic t_join_watch();
    int k;
    join_i = 1'b1;
    tick(1);
    join_i = 1'b0;
    k = 0;
    while (frames.size() < 2 && k < 2000) begin
      tick(1);
      k++;
    end
    check("joined", joined, 1'b1);
    check("join kind", frames[0][1:0], K_JOIN);
    check("join port", {frames[0][39:32], frames[0][47:40]}, PORT_JOIN);
    check("join size", frames[0][95:80], 16'(HDR));
    check("reissue flag", frames[1][8], 1'b1);
    check("reissue dest", frames[1][23:16], 8'h02);
  endtask : t_join_watch

  task automatic t_token();
    issue_i = 1'b1;
    tick(1);
    issue_i = 1'b0;
    rotate(16'h0000, 16'h0000);
    tick(1);
    check("peer token count", peer_seen_cnt, tok_cnt);
    check("peer holding", peer_hold, 1'b1);
  endtask : t_token

  task automatic t_cyc_one();
    rotate(16'h0000, 16'h0064);
  endtask : t_cyc_one

  task automatic t_cyc_split();
    rotate(16'h0000, 16'h05DC);
  endtask : t_cyc_split

  task automatic t_msg();
    rotate(16'h000A, 16'h0000);
  endtask : t_msg

  task automatic t_msg_cyc();
    rotate(16'h000A, 16'h0400);
  endtask : t_msg_cyc

  task automatic t_msg_split();
    rotate(16'h000A, 16'h0401);
  endtask : t_msg_split

  // Peer stops answering to its number; the frame it already holds carries the new one,
  // so node 8 joins the table and outlives node 7
  task automatic t_depart();
    int k;
    rotate(16'h0000, 16'h0000);
    peer_node = 8'h08;
    depart_cnt = 0;
    k = 0;
    while (depart_cnt == 0 && k < 3000) begin
      tick(1);
      k++;
    end
    check("departure", depart_cnt, 1);
    frames.delete();
    wait_tok();
    check("lone dest", frames[0][23:16], 8'h08);
  endtask : t_depart

  // A lower-numbered rival token arrives mid-segment: our token is discarded
  task automatic t_dup();
    int k;
    cyc_len = 16'h05DC;
    k = 0;
    while (holding !== 1'b0 && k < 1000) begin
      tick(1);
      k++;
    end
    while (holding !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    frames.delete();
    peer_node = 8'h01;
    issue_i   = 1'b1;
    tick(1);
    issue_i = 1'b0;
    tick(1200);
    check("segments before drop", frames.size(), 1);
    check("dropped token flag", frames[0][8], 1'b0);
  endtask : t_dup

  initial begin
    tick(16);
    rstn_i = 1'b1;
    t_reset();
    t_join_watch();
    t_token();
    t_cyc_one();
    t_cyc_split();
    t_msg();
    t_msg_cyc();
    t_msg_split();
    t_depart();
    t_dup();
    stop_test();
  end
endmodule : token_ring_frame_scheduler_tb
`default_nettype wire
